/* File: shared/ptc_defines.vh */
`ifndef PTC_DEFINES_VH
`define PTC_DEFINES_VH
// ==========================================
// Timing
`define PTC_CLK_HZ 50000000
`define PTC_TICK_MS 100
`define PTC_TICK_CYCLES ((`PTC_CLK_HZ / 1000) * `PTC_TICK_MS)
// ==========================================
// Counts and ranges
`define PTC_NUM_TIMERS 80
`define PTC_NUM_COUNTERS 40
`define PTC_NUM_AUX 800
`define PTC_CNT_SV_MAX 16'h7FFF
`define PTC_CV_RESET 16'h0000
`define PTC_NIBBLE_BITS 4
// ==========================================
// Counter arithmetic
`define PTC_SV_MIN 16'h0001
`define PTC_CV_STEP 16'h0001
`define PTC_WORD_RESET 16'h0000
// ==========================================
// BCD conversion
`define PTC_DEC_BASE 16'h000A
`define PTC_BCD_SPAN 16'h2710
`define PTC_W_THOUSANDS 16'h03E8
`define PTC_W_HUNDREDS 16'h0064
`define PTC_W_TENS 16'h000A
`define PTC_W_UNITS 16'h0001
// ==========================================
// Group operand masks
`define PTC_GRP_MASK1 16'h000F
`define PTC_GRP_MASK2 16'h00FF
`define PTC_GRP_MASK3 16'h0FFF
`define PTC_GRP_MASK4 16'hFFFF
`endif

/* File: design/ptc_timer_counter_unit.v */
`timescale 1ns/1ps
`include "ptc_defines.vh"

module ptc_timer_counter_unit #(
  parameter NUM_TIMERS = `PTC_NUM_TIMERS,
  parameter NUM_COUNTERS = `PTC_NUM_COUNTERS,
  parameter NUM_AUX = `PTC_NUM_AUX,
  parameter TICK_CYCLES = `PTC_TICK_CYCLES
)(
  input wire core_clk,
  input wire rst_n,
  input wire scan_end,
  input wire [NUM_TIMERS-1:0] timer_instruction,
  input wire [16*NUM_TIMERS-1:0] timer_set_value,
  input wire [NUM_COUNTERS-1:0] count_input_contact,
  input wire [NUM_COUNTERS-1:0] clear_input_contact,
  input wire [NUM_COUNTERS-1:0] counter_instruction,
  input wire [16*NUM_COUNTERS-1:0] counter_set_value,
  input wire [NUM_COUNTERS-1:0] counter_sv_from_reg,
  input wire [NUM_COUNTERS-1:0] cv_write,
  input wire [15:0] cv_write_data,
  input wire [NUM_AUX-1:0] aux_coil,
  input wire power_fail,
  input wire [15:0] group_bits,
  input wire [1:0] group_factor_m1,
  input wire [15:0] bin_value,
  output wire [NUM_TIMERS-1:0] timer_contact,
  output wire [16*NUM_TIMERS-1:0] timer_current,
  output wire [NUM_COUNTERS-1:0] counter_contact,
  output wire [16*NUM_COUNTERS-1:0] counter_current,
  output reg [NUM_AUX-1:0] aux_relay,
  output reg [15:0] group_word,
  output reg [15:0] bcd_word
);

  // ==========================================
  // Block behaviour
  // Within one clock a counter obeys clear first, then a current value
  // write, then a counted edge. A write while the count is done leaves the
  // done flag set, so later edges stay ignored until the next clear.
  // Power failure clears counters, timers and ordinary relays in one clock
  // and holds them cleared for as long as it stays asserted; the scan
  // engine is expected to hold it until the supply is good again.
  // All inputs except rst_n are taken as synchronous to core_clk; count inputs that come
  // from real contacts must be filtered and synchronised in front of this
  // block, since a bounce here counts as extra edges.
  // The counters and timers are wide arrays of flip-flops rather than a
  // shared memory, so every output can be read in the same clock; the cost
  // is area, which is small at these sizes.

  // ==========================================
  // Helpers

  // Constant set values are positive only, so a negative constant is read
  // as zero; a register set value passes through as a signed word.
  function [15:0] eff_sv;
    input [15:0] sv;
    input from_reg;
    reg [15:0] v;
    begin
      if (from_reg)
        v = sv;
      else if (sv[15])
        v = `PTC_CV_RESET;
      else
        v = sv;
      // Zero acts as one: the done flag sets at the first counted edge.
      if (v == `PTC_CV_RESET)
        eff_sv = `PTC_SV_MIN;
      else
        eff_sv = v;
    end
  endfunction

  // True when a counted edge must load the set value and finish the count.
  // An overshoot only counts when both words carry the same sign; with a
  // negative set value and a positive current value the count has to run on
  // through the wrap to reach it.
  function cnt_reached;
    input [15:0] cur;
    input [15:0] sv;
    reg [15:0] nxt;
    begin
      nxt = cur + `PTC_CV_STEP;
      if (cur == sv || nxt == sv)
        cnt_reached = 1'b1;
      else if (cur[15] == sv[15] && $signed(cur) > $signed(sv))
        cnt_reached = 1'b1;
      else
        cnt_reached = 1'b0;
    end
  endfunction

  // One decimal digit of v at the given weight, as a four-bit code.
  function [3:0] bcd_digit;
    input [15:0] v;
    input [15:0] weight;
    reg [15:0] q;
    begin
      q = (v / weight) % `PTC_DEC_BASE;
      bcd_digit = q[3:0];
    end
  endfunction

  // Values above four digits keep only their low four decimal digits.
  function [15:0] to_bcd;
    input [15:0] b;
    reg [15:0] v;
    begin
      v = b % `PTC_BCD_SPAN;
      to_bcd = {bcd_digit(v, `PTC_W_THOUSANDS), bcd_digit(v, `PTC_W_HUNDREDS),
        bcd_digit(v, `PTC_W_TENS), bcd_digit(v, `PTC_W_UNITS)};
    end
  endfunction

  // Mask for group factors one to four: 4, 8, 12 or 16 consecutive bits.
  function [15:0] group_mask;
    input [1:0] factor_m1;
    begin
      case (factor_m1)
        2'h0: group_mask = `PTC_GRP_MASK1;
        2'h1: group_mask = `PTC_GRP_MASK2;
        2'h2: group_mask = `PTC_GRP_MASK3;
        default: group_mask = `PTC_GRP_MASK4;
      endcase
    end
  endfunction

  // ==========================================
  // 100 ms prescaler
  // The prescaler runs free from reset, so a timer started mid-period sees
  // its first tick early: the first unit may be up to one tick short.
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;
  reg [31:0] pre_reg;
  reg tick_reg;
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end
    else if (pre_reg == TICK_LAST)
    begin
      pre_reg <= 32'h0000_0000;
      tick_reg <= 1'b1;
    end
    else
    begin
      pre_reg <= pre_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  // ==========================================
  // Timers
  // A timer stops at its set value so the contact stays on while enabled.
  // A disabled timer restarts from zero the next time it is enabled.
  genvar i;
  generate
    for (i = 0; i < NUM_TIMERS; i = i + 1)
    begin : g_tmr
      wire [15:0] sv = timer_set_value[16*i +: 16];
      wire run = timer_instruction[i] & ~power_fail;
      reg [15:0] cur_reg;
      reg contact_reg;

      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cur_reg <= `PTC_CV_RESET;
          contact_reg <= 1'b0;
        end
        else if (!run)
        begin
          cur_reg <= `PTC_CV_RESET;
          contact_reg <= 1'b0;
        end
        else
        begin
          if (tick_reg && cur_reg != sv)
            cur_reg <= cur_reg + `PTC_CV_STEP;
          contact_reg <= (cur_reg == sv);
        end
      end
      assign timer_current[16*i +: 16] = cur_reg;
      assign timer_contact[i] = contact_reg;
    end
  endgenerate

  // ==========================================
  // Counters
  // The done flag follows the count at once; the visible contact only takes
  // it over at the end of a scan, so the program sees one state per scan.
  generate
    for (i = 0; i < NUM_COUNTERS; i = i + 1)
    begin : g_cnt
      wire [15:0] sv = eff_sv(counter_set_value[16*i +: 16], counter_sv_from_reg[i]);
      reg [15:0] cur_reg;
      reg done_reg;
      reg contact_reg;
      reg prev_reg;
      // The previous sample resets low, the idle level of a count input, so an
      // input already high when reset or a power failure ends counts one edge.
      wire rise = count_input_contact[i] & ~prev_reg & counter_instruction[i];

      always @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cur_reg <= `PTC_CV_RESET;
          done_reg <= 1'b0;
          contact_reg <= 1'b0;
          prev_reg <= 1'b0;
        end
        else if (power_fail)
        begin
          cur_reg <= `PTC_CV_RESET;
          done_reg <= 1'b0;
          contact_reg <= 1'b0;
          prev_reg <= 1'b0;
        end
        else
        begin
          prev_reg <= count_input_contact[i];
          if (clear_input_contact[i])
          begin
            cur_reg <= `PTC_CV_RESET;
            done_reg <= 1'b0;
          end
          else if (cv_write[i])
            cur_reg <= cv_write_data;
          else if (rise && !done_reg)
          begin
            if (cnt_reached(cur_reg, sv))
            begin
              cur_reg <= sv;
              done_reg <= 1'b1;
            end
            else
              cur_reg <= cur_reg + `PTC_CV_STEP;
          end
          if (scan_end)
            contact_reg <= clear_input_contact[i] ? 1'b0 : done_reg;
        end
      end
      assign counter_current[16*i +: 16] = cur_reg;
      assign counter_contact[i] = contact_reg;
    end
  endgenerate

  // ==========================================
  // Auxiliary relays
  // Ordinary relays drop on a power failure and follow their coils again
  // from the first clock after it ends.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      aux_relay <= {NUM_AUX{1'b0}};
    else if (power_fail)
      aux_relay <= {NUM_AUX{1'b0}};
    else
      aux_relay <= aux_coil;
  end

  // ==========================================
  // Operand grouping and BCD
  // Both converters are registered so their outputs come from flip-flops;
  // the result follows its operand by one clock.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      group_word <= `PTC_WORD_RESET;
    else
      group_word <= group_bits & group_mask(group_factor_m1);
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      bcd_word <= `PTC_WORD_RESET;
    else
      bcd_word <= to_bcd(bin_value);
  end

endmodule // ptc_timer_counter_unit

/* File: verif/ptc_scan_model.sv */
`timescale 1ns/1ps
// ====
// Scan engine: every scan lasts SCAN cycles and ends with a one-cycle pulse.
module ptc_scan_model #(parameter SCAN = 6) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic scan_end
);
  logic [3:0] phase_reg;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      {phase_reg, scan_end} <= 5'h00;
    else
    begin
      phase_reg <= (phase_reg == SCAN - 1) ? 4'h0 : phase_reg + 4'h1;
      scan_end <= (phase_reg == SCAN - 1);
    end
endmodule // ptc_scan_model

/* File: verif/ptc_monitor.sv */
`timescale 1ns/1ps
// ====
// Watches counter 0, timer 0 and the relays.
module ptc_monitor #(parameter NUM_TIMERS = 1, NUM_COUNTERS = 1, NUM_AUX = 4) (
  input core_clk,
  input rst_n,
  input scan_end,
  input power_fail,
  input [NUM_COUNTERS-1:0] count_input_contact,
  input [NUM_COUNTERS-1:0] clear_input_contact,
  input [NUM_COUNTERS-1:0] counter_instruction,
  input [NUM_COUNTERS-1:0] cv_write,
  input [16*NUM_COUNTERS-1:0] counter_set_value,
  input [16*NUM_COUNTERS-1:0] counter_current,
  input [NUM_COUNTERS-1:0] counter_contact,
  input [16*NUM_TIMERS-1:0] timer_set_value,
  input [16*NUM_TIMERS-1:0] timer_current,
  input [NUM_TIMERS-1:0] timer_contact,
  input [NUM_AUX-1:0] aux_relay
);
  wire [15:0] cv = counter_current[15:0];
  wire [15:0] sv = counter_set_value[15:0];
  wire pos = sv != 16'h0000 && !sv[15];
  wire calm = !clear_input_contact[0] && !cv_write[0] && !power_fail;
  wire cc = counter_contact[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  count_step_a: assert property ($rose(count_input_contact[0]) && counter_instruction[0]
    && calm && pos && cv < sv |=> cv == $past(cv) + 16'h0001) else $error("step");
  count_hold_a: assert property (cv == sv && pos && calm |=> $stable(cv))
    else $error("hold");
  clear_zero_a: assert property (clear_input_contact[0] |=> cv == 16'h0000)
    else $error("clear");
  scan_sync_a: assert property (!$stable(cc) |-> $past(scan_end) || $past(power_fail))
    else $error("sync");
  contact_set_a: assert property (scan_end && cv == sv && pos && calm |=> cc)
    else $error("set");
  contact_keep_a: assert property (cc && calm |=> cc)
    else $error("keep");
  power_off_a: assert property (power_fail |=> aux_relay == '0 && cv == 16'h0000)
    else $error("power");
  timer_match_a: assert property ($rose(timer_contact[0])
    |-> $past(timer_current[15:0] == timer_set_value[15:0])) else $error("timer");
  cover property (scan_end && cc);
  cover property ($rose(timer_contact[0]));
  cover property (power_fail);
endmodule // ptc_monitor

/* File: verif/plc_timer_counter_unit_tb_top.sv */
`timescale 1ns/1ps
// ====
// Bench for counter 0, timer 0, relays and the operand converters.
module plc_timer_counter_unit_tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, scan_end, timer_contact, counter_contact;
  logic timer_instruction, count_input_contact, clear_input_contact, counter_instruction;
  logic counter_sv_from_reg, cv_write, power_fail;
  logic [1:0] group_factor_m1;
  logic [3:0] aux_coil, aux_relay;
  logic [15:0] timer_set_value, counter_set_value, cv_write_data, group_bits, bin_value;
  logic [15:0] timer_current, counter_current, group_word, bcd_word;
  integer seed = 44013, mismatches = 0, checked = 0, n;
  ptc_timer_counter_unit #(.NUM_TIMERS(1), .NUM_COUNTERS(1), .NUM_AUX(4), .TICK_CYCLES(10))
    dut (.core_clk(core_clk), .rst_n(rst_n), .scan_end(scan_end),
    .timer_instruction(timer_instruction), .timer_set_value(timer_set_value),
    .count_input_contact(count_input_contact), .clear_input_contact(clear_input_contact),
    .counter_instruction(counter_instruction), .counter_set_value(counter_set_value),
    .counter_sv_from_reg(counter_sv_from_reg), .cv_write(cv_write),
    .cv_write_data(cv_write_data), .aux_coil(aux_coil), .power_fail(power_fail),
    .group_bits(group_bits), .group_factor_m1(group_factor_m1), .bin_value(bin_value),
    .timer_contact(timer_contact), .timer_current(timer_current),
    .counter_contact(counter_contact), .counter_current(counter_current),
    .aux_relay(aux_relay), .group_word(group_word), .bcd_word(bcd_word));
  ptc_scan_model scan_eng (.core_clk(core_clk), .rst_n(rst_n), .scan_end(scan_end));
  initial forever #10 core_clk = ~core_clk;
  task cyc(input integer k);
    repeat (k) @(posedge core_clk);
  endtask
  task chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task pulse;
    @(posedge core_clk) count_input_contact <= 1'b1;
    @(posedge core_clk) count_input_contact <= 1'b0;
    cyc(1);
  endtask
  task scan;
    n = 0;
    cyc(1);
    while (scan_end !== 1'b1 && n < 50)
    begin
      cyc(1);
      n++;
    end
    chk("scan", 16'h0000, n == 50);
    cyc(1);
  endtask
  task clr;
    clear_input_contact <= 1'b1;
    scan;
    clear_input_contact <= 1'b0;
  endtask
  task wr(input logic [15:0] d);
    cv_write_data <= d;
    cv_write <= 1'b1;
    @(posedge core_clk) cv_write <= 1'b0;
  endtask
  function logic [15:0] bcd(input logic [15:0] v);
    integer k;
    k = v % 10000;
    bcd = {4'(k / 1000), 4'(k / 100 % 10), 4'(k / 10 % 10), 4'(k % 10)};
  endfunction
  task final_report;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {timer_instruction, count_input_contact, clear_input_contact, counter_instruction} <= '0;
    {counter_sv_from_reg, cv_write, power_fail, group_factor_m1, aux_coil} <= '0;
    {timer_set_value, counter_set_value, cv_write_data, group_bits, bin_value} <= '0;
    cyc(8);
    rst_n <= 1'b1;
    counter_instruction <= 1'b1;
    counter_set_value <= 16'h0005;
    pulse;
    chk("cur", 16'h0001, counter_current);
    repeat (7) pulse;
    chk("cur", 16'h0005, counter_current);
    scan;
    chk("contact", 16'h0001, counter_contact);
    clr;
    chk("cur", 16'h0000, counter_current);
    chk("contact", 16'h0000, counter_contact);
    counter_set_value <= 16'h0000;
    pulse;
    scan;
    chk("contact", 16'h0001, counter_contact);
    clr;
    counter_set_value <= 16'h0005;
    wr(16'h0064);
    pulse;
    chk("cur", 16'h0005, counter_current);
    clr;
    counter_set_value <= 16'h7FFF;
    wr(16'h7FFE);
    pulse;
    chk("cur", 16'h7FFF, counter_current);
    clr;
    counter_sv_from_reg <= 1'b1;
    counter_set_value <= 16'hFFFD;
    wr(16'hFFFB);
    pulse;
    chk("cur", 16'hFFFC, counter_current);
    counter_set_value <= 16'h8001;
    wr(16'h7FFF);
    pulse;
    chk("cur", 16'h8000, counter_current);
    aux_coil <= 4'($random(seed));
    power_fail <= 1'b1;
    cyc(2);
    chk("relay", 16'h0000, aux_relay);
    chk("cur", 16'h0000, counter_current);
    power_fail <= 1'b0;
    timer_set_value <= 16'h0003;
    timer_instruction <= 1'b1;
    n = 0;
    while (timer_contact !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    chk("timer", 16'h0003, timer_current);
    chk("elapsed", 16'h0001, n > 20 && n < 34);
    repeat (8)
    begin
      group_bits <= 16'($random(seed));
      bin_value <= 16'($random(seed));
      group_factor_m1 <= 2'($random(seed));
      cyc(2);
      chk("group", group_bits & ~(16'hFFFF << 4 * group_factor_m1 + 4), group_word);
      chk("bcd", bcd(bin_value), bcd_word);
    end
    final_report;
  end
endmodule // plc_timer_counter_unit_tb_top
bind ptc_timer_counter_unit ptc_monitor #(.NUM_TIMERS(NUM_TIMERS),
  .NUM_COUNTERS(NUM_COUNTERS), .NUM_AUX(NUM_AUX)) mon (.core_clk(core_clk), .rst_n(rst_n),
  .scan_end(scan_end), .power_fail(power_fail), .count_input_contact(count_input_contact),
  .clear_input_contact(clear_input_contact), .counter_instruction(counter_instruction),
  .cv_write(cv_write), .counter_set_value(counter_set_value),
  .counter_current(counter_current), .counter_contact(counter_contact),
  .timer_set_value(timer_set_value), .timer_current(timer_current),
  .timer_contact(timer_contact), .aux_relay(aux_relay));
